// ---- core/hpm_defines.svh ----
// Purpose: constants for the host parallel port mailbox block
// Assumes: 20 MHz system clock
// Notes:   offsets are port select codes on the two address pins
`ifndef HPM_DEFINES_SVH
`define HPM_DEFINES_SVH
`define HPM_SEL_DATA      2'h0
`define HPM_SEL_MBOX      2'h1
`define HPM_SEL_ADDR      2'h2
`define HPM_SEL_STAT      2'h3
`define HPM_WORD_W        16
`define HPM_PTR_RST       16'h0000
`define HPM_MBOX_RST      16'h0000
`define HPM_TEST_TIME_US  3000
`define HPM_CLK_MHZ       20
`define HPM_TEST_CYC      (`HPM_TEST_TIME_US * `HPM_CLK_MHZ)
`define HPM_STAT_OUT_BIT  0
`define HPM_STAT_IN_BIT   1
`define HPM_STAT_TEST_BIT 2
`define HPM_STAT_ACT_BIT  3
`endif

// ---- core/hpm_pkg.sv ----
// Purpose: types for the host parallel port mailbox block
// Assumes: nothing
// Notes:   constants live in hpm_defines.svh
package hpm_pkg;
  typedef enum logic [1:0] {
    HPM_BOOT   = 2'b00,
    HPM_TEST   = 2'b01,
    HPM_ACTIVE = 2'b11,
    HPM_OFF    = 2'b10
  } hpm_mode_e;
endpackage : hpm_pkg

// ---- core/hpm_port.sv ----
// Purpose: 16-bit strobed host port with memory pointer and mailbox
// Assumes: SYS_CLK 20 MHz, async host strobes synchronised here
// Notes:   memory side is a simple one-cycle request port
`timescale 1ns/100ps
`include "hpm_defines.svh"
module hpm_port
  import hpm_pkg::*;
#(
  parameter int unsigned TEST_CYC = `HPM_TEST_CYC
)(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic [1:0]  BOOT_SEL,
  input  wire logic        READ_STROBE_N,
  input  wire logic        WRITE_STROBE_N,
  input  wire logic        CHIP_SELECT_N,
  input  wire logic        PORT_SEL_HI,
  input  wire logic        PORT_SEL_LO,
  input  wire logic [15:0] PORT_WORD_IN,
  output logic      [15:0] PORT_WORD_OUT,
  output logic             PORT_WORD_OE,
  output logic             TEST_PIN_OE,
  output logic             MAILBOX_OUT_IRQ,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [15:0] MEM_ADDR,
  output logic      [15:0] MEM_WDATA,
  input  wire logic [15:0] MEM_RDATA,
  input  wire logic        FW_MBOX_WE,
  input  wire logic [15:0] FW_MBOX_WDATA,
  input  wire logic        FW_MBOX_IN_ACK,
  output logic      [15:0] FW_MBOX_RDATA,
  output logic             FW_MBOX_IN_FLAG
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // each strobe/select/data input gets two flops before use
  localparam int unsigned SW = 21;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  assign pin_raw = {READ_STROBE_N, WRITE_STROBE_N, CHIP_SELECT_N,
                    PORT_SEL_HI, PORT_SEL_LO, PORT_WORD_IN};

  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++)
    begin : g_sync
      always_ff @(posedge SYS_CLK or negedge RST_B)
      begin
        if (!RST_B)
        begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  logic        rd_n_s;
  logic        wr_n_s;
  logic        cs_n_s;
  logic [1:0]  sel_s;
  logic [15:0] din_s;
  logic        rd_rise;
  logic        wr_rise;
  logic        rd_low;
  assign rd_n_s  = s2_q[20];
  assign wr_n_s  = s2_q[19];
  assign cs_n_s  = s2_q[18];
  assign sel_s   = s2_q[17:16];
  assign din_s   = s2_q[15:0];
  // held select and data stay valid through the strobe edge
  assign rd_rise = rd_n_s & ~s3_q[20] & ~s3_q[18];
  assign wr_rise = wr_n_s & ~s3_q[19] & ~s3_q[18];
  assign rd_low  = ~rd_n_s & ~cs_n_s;

  // ----------------------------------------------------------------
  // mode: boot strap, then test window and active, or off
  // ----------------------------------------------------------------
  hpm_mode_e   mode_q;
  hpm_mode_e   mode_d;
  logic [31:0] tcnt_q;
  logic [31:0] tcnt_d;
  logic [1:0]  boot_s1_q;
  logic [1:0]  boot_s2_q;

  // no reset: the strap settles through both flops while reset is held
  always_ff @(posedge SYS_CLK)
  begin
    boot_s1_q <= BOOT_SEL;
    boot_s2_q <= boot_s1_q;
  end

  always_comb
  begin
    mode_d = mode_q;
    tcnt_d = tcnt_q;
    case (mode_q)
      HPM_BOOT:
        // strap taken by the first clock after release, never in reset
        mode_d = (boot_s2_q == 2'h0) ? HPM_TEST : HPM_OFF;
      HPM_TEST:
      begin
        tcnt_d = tcnt_q + 32'h1;
        if (tcnt_q >= TEST_CYC - 1)
          mode_d = HPM_ACTIVE;
      end
      HPM_ACTIVE: mode_d = HPM_ACTIVE;
      HPM_OFF:    mode_d = HPM_OFF;
      default:    mode_d = HPM_OFF;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode_q <= HPM_BOOT;
      tcnt_q <= 32'h0;
    end
    else
    begin
      mode_q <= mode_d;
      tcnt_q <= tcnt_d;
    end
  end

  logic act;
  assign act = (mode_q == HPM_ACTIVE);

  // ----------------------------------------------------------------
  // port registers and memory access
  // ----------------------------------------------------------------
  logic [15:0] ptr_q,  ptr_d;
  logic [15:0] mout_q, mout_d;
  logic [15:0] min_q,  min_d;
  logic        opend_q, opend_d;
  logic        iflag_q, iflag_d;
  logic [15:0] dout_q, dout_d;
  logic        oe_q,   oe_d;
  logic        toe_q,  toe_d;
  logic        mreq_q, mreq_d;
  logic        mwe_q,  mwe_d;
  logic [15:0] maddr_q, maddr_d;
  logic [15:0] mwd_q,  mwd_d;
  logic [15:0] stat_w;

  assign stat_w = {12'h000, act, (mode_q == HPM_TEST), iflag_q, opend_q};

  always_comb
  begin
    ptr_d   = ptr_q;
    mout_d  = mout_q;
    min_d   = min_q;
    opend_d = opend_q;
    iflag_d = iflag_q;
    dout_d  = dout_q;
    mreq_d  = 1'b0;
    mwe_d   = 1'b0;
    maddr_d = maddr_q;
    mwd_d   = mwd_q;
    oe_d    = act & rd_low;
    toe_d   = (mode_q == HPM_TEST);
    // firmware side of the mailbox; clear first so a new event wins
    if (FW_MBOX_IN_ACK)
      iflag_d = 1'b0;
    if (act && rd_rise && sel_s == `HPM_SEL_MBOX)
      opend_d = 1'b0;
    if (FW_MBOX_WE)
    begin
      mout_d  = FW_MBOX_WDATA;
      opend_d = 1'b1;
    end
    // read data presented while the strobe is low
    if (act && rd_low)
    begin
      case (sel_s)
        `HPM_SEL_DATA: dout_d = MEM_RDATA;
        `HPM_SEL_MBOX: dout_d = mout_q;
        `HPM_SEL_ADDR: dout_d = ptr_q;
        `HPM_SEL_STAT: dout_d = stat_w;
        default:       dout_d = 16'h0000;
      endcase
    end
    if (act && wr_rise)
    begin
      case (sel_s)
        `HPM_SEL_DATA:
        begin
          mreq_d  = 1'b1;
          mwe_d   = 1'b1;
          maddr_d = ptr_q;
          mwd_d   = din_s;
          ptr_d   = ptr_q + 16'h0001;
        end
        `HPM_SEL_MBOX:
        begin
          min_d   = din_s;
          iflag_d = 1'b1;
        end
        `HPM_SEL_ADDR: ptr_d = din_s;
        default:       ptr_d = ptr_q;                        // status is read only
      endcase
    end
    else if (act && rd_rise && sel_s == `HPM_SEL_DATA)
    begin
      mreq_d = 1'b1;
      maddr_d = ptr_q;
      ptr_d  = ptr_q + 16'h0001;
    end
    // address follows the pointer so read data is ready during the strobe
    if (!mreq_d)
      maddr_d = ptr_d;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ptr_q   <= `HPM_PTR_RST;
      mout_q  <= `HPM_MBOX_RST;
      min_q   <= `HPM_MBOX_RST;
      opend_q <= 1'b0;
      iflag_q <= 1'b0;
      dout_q  <= 16'h0000;
      oe_q    <= 1'b0;
      toe_q   <= 1'b0;
      mreq_q  <= 1'b0;
      mwe_q   <= 1'b0;
      maddr_q <= `HPM_PTR_RST;
      mwd_q   <= 16'h0000;
    end
    else
    begin
      ptr_q   <= ptr_d;
      mout_q  <= mout_d;
      min_q   <= min_d;
      opend_q <= opend_d;
      iflag_q <= iflag_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      toe_q   <= toe_d;
      mreq_q  <= mreq_d;
      mwe_q   <= mwe_d;
      maddr_q <= maddr_d;
      mwd_q   <= mwd_d;
    end
  end

  assign PORT_WORD_OUT   = dout_q;
  assign PORT_WORD_OE    = oe_q;
  assign TEST_PIN_OE     = toe_q;
  assign MAILBOX_OUT_IRQ = opend_q;
  assign MEM_REQ         = mreq_q;
  assign MEM_WE          = mwe_q;
  assign MEM_ADDR        = maddr_q;
  assign MEM_WDATA       = mwd_q;
  assign FW_MBOX_RDATA   = min_q;
  assign FW_MBOX_IN_FLAG = iflag_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ptr_advance: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    act && (wr_rise || rd_rise) && sel_s == `HPM_SEL_DATA
    |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer did not advance");
  a_mem_write: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    act && wr_rise && sel_s == `HPM_SEL_DATA
    |=> MEM_REQ && MEM_WE && MEM_ADDR == $past(ptr_q) && MEM_WDATA == $past(din_s))
    else $error("data write not sent to memory");
  a_irq_set: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    FW_MBOX_WE |=> MAILBOX_OUT_IRQ)
    else $error("outgoing mailbox irq missing");
  a_irq_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    act && rd_rise && sel_s == `HPM_SEL_MBOX && !FW_MBOX_WE |=> !MAILBOX_OUT_IRQ)
    else $error("irq not released on mailbox read");
  a_mbox_in: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    act && wr_rise && sel_s == `HPM_SEL_MBOX
    |=> FW_MBOX_IN_FLAG && FW_MBOX_RDATA == $past(din_s))
    else $error("inbound mailbox not captured");
  a_stat_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    act && rd_rise && sel_s == `HPM_SEL_STAT |=> !MEM_REQ && $stable(ptr_q))
    else $error("status read disturbed memory");
  a_addr_load: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    act && wr_rise && sel_s == `HPM_SEL_ADDR |=> ptr_q == $past(din_s))
    else $error("pointer load failed");
  a_off_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    mode_q == HPM_OFF |-> !PORT_WORD_OE && !MEM_REQ && !TEST_PIN_OE)
    else $error("port active while not selected");
  a_test_oe: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    mode_q == HPM_TEST ##1 mode_q == HPM_TEST |-> TEST_PIN_OE && !MEM_REQ)
    else $error("test window pin drive wrong");
  c_block_write: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    MEM_WE ##[1:200] MEM_WE);
  c_mbox_round: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    MAILBOX_OUT_IRQ ##[1:200] !MAILBOX_OUT_IRQ);
  c_data_read: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    MEM_REQ && !MEM_WE);

endmodule : hpm_port

// ---- verif/hpm_host_model.sv ----
// Purpose: host processor model for the strobed port
// Assumes: strobe phases timed in SYS_CLK cycles
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/100ps
module hpm_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus,
  output logic             rd_n = 1'b1,
  output logic             wr_n = 1'b1,
  output logic             cs_n = 1'b1,
  output logic [1:0]       sel  = 2'h0,
  output logic [15:0]      drv  = 16'h0000
);
  // ----------------------------------------
  // one strobe cycle
  // ----------------------------------------
  // strobe low 6 clocks, then select and data held 4 clocks past the rise
  task xfer(input logic wr, input logic csel, input logic [1:0] s, input logic [15:0] wd,
            output logic [15:0] rd);
    @(posedge clk);
    cs_n <= ~csel;
    sel  <= s;
    drv  <= wd;
    wr_n <= ~wr;
    rd_n <= wr;
    repeat (6) @(posedge clk);
    rd = bus;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // no pull on the data lines, so a stale word must not linger
    drv  <= ~drv;
    repeat (3) @(posedge clk);
  endtask : xfer
endmodule : hpm_host_model

// ---- verif/hpm_port_tb_top.sv ----
// Purpose: self-checking bench for the host port
// Assumes: memory side modelled here as 64 words
// Notes:   test window shortened through TEST_CYC
`timescale 1ns/100ps
`include "hpm_defines.svh"
module hpm_port_tb_top;
  localparam int TEST_N = 10;
  logic        sys_clk  = 1'b0;
  logic        rst_b    = 1'b0;
  logic [1:0]  boot_sel = 2'h0;
  logic        fw_we    = 1'b0;
  logic        fw_ack   = 1'b0;
  logic [15:0] fw_wd    = 16'h0000;
  logic        rd_n, wr_n, cs_n, word_oe, test_oe, irq, mem_req, mem_we, fw_flag;
  logic [1:0]  sel;
  logic [15:0] drv, bus, word_out, mem_addr, mem_wdata, mem_rdata, fw_rd, rd;
  logic [15:0] mem [0:63];
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          nreq = 0;
  int          noe = 0;
  int          k, n0, o0;
  // ----------------------------------------
  // clock, bus, memory
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;
  assign bus       = word_oe ? word_out : drv;
  assign mem_rdata = mem[mem_addr[5:0]];
  always @(posedge sys_clk)
  begin
    cyc++;
    if (mem_req) nreq++;
    if (word_oe) noe++;
    if (mem_req && mem_we) mem[mem_addr[5:0]] <= mem_wdata;
    if (cyc == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end
  hpm_port #(.TEST_CYC(TEST_N)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .BOOT_SEL(boot_sel), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .CHIP_SELECT_N(cs_n), .PORT_SEL_HI(sel[1]), .PORT_SEL_LO(sel[0]),
    .PORT_WORD_IN(bus), .PORT_WORD_OUT(word_out), .PORT_WORD_OE(word_oe),
    .TEST_PIN_OE(test_oe), .MAILBOX_OUT_IRQ(irq), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .FW_MBOX_WE(fw_we),
    .FW_MBOX_WDATA(fw_wd), .FW_MBOX_IN_ACK(fw_ack), .FW_MBOX_RDATA(fw_rd),
    .FW_MBOX_IN_FLAG(fw_flag));
  hpm_host_model u_host (
    .clk(sys_clk), .bus(bus), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .sel(sel), .drv(drv));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_boot;
    repeat (3) @(posedge sys_clk);
    chk({15'h0, test_oe}, 16'h0001);
    for (k = 0; k < TEST_N + 5 && test_oe; k++) @(posedge sys_clk);
    chk({15'h0, test_oe}, 16'h0000);
    u_host.xfer(1'b0, 1'b1, `HPM_SEL_STAT, 16'h0000, rd);
    chk(rd & 16'h000C, 16'h0008);
    $display("t_boot done");
  endtask : t_boot
  task t_block;
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_ADDR, 16'h0010, rd);
    n0 = nreq;
    for (k = 0; k < 3; k++) u_host.xfer(1'b1, 1'b1, `HPM_SEL_DATA, 16'hA500 + k, rd);
    chk(16'(nreq - n0), 16'h0003);
    for (k = 0; k < 3; k++) chk(mem[16 + k], 16'hA500 + k);
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_ADDR, 16'h0010, rd);
    for (k = 0; k < 3; k++)
    begin
      u_host.xfer(1'b0, 1'b1, `HPM_SEL_DATA, 16'h0000, rd);
      chk(rd, 16'hA500 + k);
    end
    // pointer wraps from the top word to zero
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_ADDR, 16'hFFFF, rd);
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_DATA, 16'h1234, rd);
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_DATA, 16'h5678, rd);
    chk(mem[63], 16'h1234);
    chk(mem[0], 16'h5678);
    n0 = nreq;
    u_host.xfer(1'b1, 1'b0, `HPM_SEL_DATA, 16'hDEAD, rd);
    chk(16'(nreq - n0), 16'h0000);
    $display("t_block done");
  endtask : t_block
  task t_mbox;
    @(posedge sys_clk);
    fw_we <= 1'b1;
    fw_wd <= 16'hC3C3;
    @(posedge sys_clk);
    fw_we <= 1'b0;
    @(negedge sys_clk);
    chk({15'h0, irq}, 16'h0001);
    n0 = nreq;
    u_host.xfer(1'b0, 1'b1, `HPM_SEL_STAT, 16'h0000, rd);
    chk(rd & 16'h0001, 16'h0001);
    chk(16'(nreq - n0), 16'h0000);
    u_host.xfer(1'b0, 1'b1, `HPM_SEL_MBOX, 16'h0000, rd);
    chk(rd, 16'hC3C3);
    chk({15'h0, irq}, 16'h0000);
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_MBOX, 16'h5AA5, rd);
    chk({15'h0, fw_flag}, 16'h0001);
    chk(fw_rd, 16'h5AA5);
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_STAT, 16'hFFFF, rd);
    u_host.xfer(1'b0, 1'b1, `HPM_SEL_STAT, 16'h0000, rd);
    chk(rd & 16'h000F, 16'h000A);
    @(posedge sys_clk);
    fw_ack <= 1'b1;
    @(posedge sys_clk);
    fw_ack <= 1'b0;
    @(negedge sys_clk);
    chk({15'h0, fw_flag}, 16'h0000);
    $display("t_mbox done");
  endtask : t_mbox
  task t_off;
    @(posedge sys_clk);
    rst_b    <= 1'b0;
    boot_sel <= 2'h1;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (TEST_N + 5) @(posedge sys_clk);
    n0 = nreq;
    o0 = noe;
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_ADDR, 16'h0004, rd);
    u_host.xfer(1'b1, 1'b1, `HPM_SEL_DATA, 16'hBEEF, rd);
    u_host.xfer(1'b0, 1'b1, `HPM_SEL_STAT, 16'h0000, rd);
    chk(16'(nreq - n0), 16'h0000);
    chk(16'(noe - o0), 16'h0000);
    $display("t_off done");
  endtask : t_off
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_boot();
    t_block();
    t_mbox();
    t_off();
    end_sim();
  end
endmodule : hpm_port_tb_top
